/* rtl/fld_decoder.sv */
// floating-point load/store and computational instruction decoder
// Summary of operation
// - stall the instruction right after a load that reads the loaded register
// - width bit clear: 32-bit registers, singles only in even registers
// - width bit clear: double is even (low) plus odd (high) pair
// - width bit set: thirty-two 64-bit registers, any register usable
// - width mode comes from status bit 26; clear means even numbers only
// - load/store word: opcode 31..26, base 25..21, register 20..16, offset 15..0
// - word access uses word type and needs two low address bits zero
// - doubleword access uses doubleword type and three low address bits zero
// - effective address names the lowest-addressed byte in either byte order
// - translation misses raise a TLB miss exception
// - loads fetch word or doubleword, filling cache when enabled
// - split compute word into opcode, format, two sources, destination, function
// - format 16 single, 17 double, 20 word, 21 long; rest reserved
// - function 0..7: add, sub, mul, div, root, magnitude, transfer, negate
// - 8..11 to long, 12..15 to word; nearest, zero, up, down
// - 32 to single, 33 to double, 36 to word, 37 to long
// - 48..63 compare; 16..31, 34, 35, 38..47 reserved, no operation
// - loads and stores use raw numbers, operations use format view
// - width bit set: odd and even numbers both valid
// - 32-bit mode double joins odd upper and even lower; single leaves odd undefined
// - odd register in 32-bit mode gives undefined result
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module fld_decoder
    import fld_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RESETN,
    // issue from the integer pipeline
    input  wire logic              ISSUE_VALID,
    input  wire logic              ISSUE_IS_LOAD,
    input  wire logic              ISSUE_IS_STORE,
    input  wire logic              ISSUE_DOUBLE,
    input  wire logic [31:0]       ISSUE_WORD,
    input  wire logic [ADDR_W-1:0] ISSUE_BASE_VALUE,
    output logic                   ISSUE_STALL,
    // translation and memory side
    input  wire logic              TLB_HIT,
    input  wire logic              CACHE_ENABLE,
    output fld_mem_t               MEM_REQ,
    output logic                   MEM_CACHE_FILL,
    output logic                   ADDR_ERROR,
    output logic                   TLB_MISS,
    // compute side
    output fld_exec_t              EXEC_REQ,
    output fld_fields_t            FIELDS,
    // Avalon-MM slave
    input  wire logic [3:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output logic [31:0]            AVS_READDATA,
    output logic                   AVS_WAITREQUEST
);

    // elaboration-time check of the address width
    if (ADDR_W != 32) begin : g_bad_addr_w
        $error("fld_decoder supports ADDR_W of 32 only");
    end

    fld_state_t  s_q;
    fld_state_t  s_d;
    logic        width64;
    fld_fields_t f;
    logic [31:0] eaddr;
    logic        hazard;
    logic        fmt_ok;
    logic        fn_ok;
    fld_opkind_t kind;
    logic        accept;
    logic        is_ls;
    logic        bus_req;

    assign width64 = s_q.status[STATUS_WIDTH_BIT];

    always_comb begin
        f.opcode  = ISSUE_WORD[OP_HI:OP_LO];
        f.base    = ISSUE_WORD[BASE_HI:BASE_LO];
        f.fmt     = ISSUE_WORD[BASE_HI:BASE_LO];
        f.src_two = ISSUE_WORD[SRCB_HI:SRCB_LO];
        f.src_one = ISSUE_WORD[SRCA_HI:SRCA_LO];
        f.dest    = ISSUE_WORD[DST_HI:DST_LO];
        f.func    = ISSUE_WORD[FN_HI:FN_LO];
        f.offset  = ISSUE_WORD[OFS_HI:OFS_LO];
    end

    // sign-extended offset added to base gives the lowest byte address
    assign eaddr = ISSUE_BASE_VALUE + {{16{f.offset[15]}}, f.offset};

    assign is_ls = ISSUE_IS_LOAD || ISSUE_IS_STORE;

    // dependent read of a register still being loaded
    always_comb begin
        hazard = 1'b0;
        if (s_q.load_pending && ISSUE_VALID) begin
            if (is_ls)
                hazard = ISSUE_IS_STORE && (f.src_two == s_q.load_dest);
            else
                hazard = (f.src_one == s_q.load_dest) || (f.src_two == s_q.load_dest);
        end
    end

    assign ISSUE_STALL = hazard || (s_q.pipe == PS_STALL);
    assign accept      = ISSUE_VALID && !ISSUE_STALL;

    always_comb begin
        fmt_ok = (f.fmt == FMT_SINGLE) || (f.fmt == FMT_DOUBLE) ||
                 (f.fmt == FMT_WORD) || (f.fmt == FMT_LONG);
    end

    always_comb begin
        kind = OPK_NONE;
        if (f.func <= FN_TOWORD_HI)
            kind = fld_opkind_t'({1'b0, f.func[3:0]});
        else if (f.func == FN_TO_SINGLE)
            kind = OPK_TOS;
        else if (f.func == FN_TO_DOUBLE)
            kind = OPK_TOD;
        else if (f.func == FN_TO_WORD)
            kind = OPK_TOW;
        else if (f.func == FN_TO_LONG)
            kind = OPK_TOL;
        else if (f.func >= FN_COMPARE_LO)
            kind = OPK_CMP;
        fn_ok = (kind != OPK_NONE);
    end

    assign bus_req = AVS_READ || AVS_WRITE;

    always_comb begin
        s_d = s_q;
        s_d.mem.valid  = 1'b0;
        s_d.exec.valid = 1'b0;
        // stall sequencing
        case (s_q.pipe)
            PS_IDLE: begin
                if (hazard) begin
                    s_d.pipe      = PS_STALL;
                    s_d.stall_cnt = LOAD_STALL_CYCLES;
                    s_d.stalls    = s_q.stalls + 16'h0001;
                end
            end
            PS_STALL: begin
                if (s_q.stall_cnt == 2'h1) begin
                    s_d.pipe         = PS_IDLE;
                    s_d.load_pending = 1'b0;
                end
                s_d.stall_cnt = s_q.stall_cnt - 2'h1;
            end
            default: s_d.pipe = PS_IDLE;
        endcase
        if (s_q.pipe == PS_IDLE && !hazard)
            s_d.load_pending = 1'b0;
        if (accept) begin
            s_d.fields = f;
            if (is_ls) begin
                s_d.mem.is_store = ISSUE_IS_STORE;
                s_d.mem.acc      = ISSUE_DOUBLE ? ACC_DOUBLE : ACC_WORD;
                s_d.mem.vaddr    = eaddr;
                // raw register number addressing for memory moves
                s_d.mem.row       = width64 ? f.src_two : {f.src_two[4:1], 1'b0};
                s_d.mem.high_half = !width64 && f.src_two[0];
                s_d.align_fault   = ISSUE_DOUBLE ? (eaddr[2:0] != 3'h0)
                                                 : (eaddr[1:0] != 2'h0);
                s_d.tlb_fault     = !TLB_HIT;
                s_d.mem.valid     = !s_d.align_fault && TLB_HIT;
                if (ISSUE_IS_LOAD) begin
                    s_d.load_pending = 1'b1;
                    s_d.load_dest    = f.src_two;
                end
            end else if (f.opcode == FLOAT_COPROCESSOR_OPCODE) begin
                s_d.exec.valid         = 1'b1;
                s_d.exec.kind          = kind;
                // value view: pair rows in 32-bit mode, whole rows in 64-bit mode
                s_d.exec.src_one_row   = width64 ? f.src_one : {f.src_one[4:1], 1'b0};
                s_d.exec.src_two_row   = width64 ? f.src_two : {f.src_two[4:1], 1'b0};
                s_d.exec.dest_row      = width64 ? f.dest : {f.dest[4:1], 1'b0};
                s_d.exec.pair_access   = !width64 && ((f.fmt == FMT_DOUBLE) ||
                                                      (f.fmt == FMT_LONG));
                s_d.exec.odd_register  = !width64 && (f.src_one[0] || f.src_two[0] ||
                                                      f.dest[0]);
                s_d.exec.unimplemented = !fmt_ok || !fn_ok;
                s_d.exec.dest_write    = fmt_ok && fn_ok && (kind != OPK_CMP);
                s_d.align_fault        = 1'b0;
                s_d.tlb_fault          = 1'b0;
            end
        end
        // register bus
        s_d.waitreq = 1'b1;
        if (bus_req && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata   = 32'h0000_0000;
            case (AVS_ADDRESS)
                ADDR_STATUS: s_d.rdata = s_q.status;
                ADDR_DECODE: s_d.rdata = {24'h00_0000, 3'h0, s_q.exec.kind};
                ADDR_COUNT:  s_d.rdata = {16'h0000, s_q.stalls};
                default:     s_d.rdata = 32'h0000_0000;
            endcase
        end
        // a write lands at the edge that completes the access
        if (AVS_WRITE && !s_q.waitreq && AVS_ADDRESS == ADDR_STATUS) begin
            for (int i = 0; i < 4; i++) begin
                if (AVS_BYTEENABLE[i])
                    s_d.status[i*8 +: 8] = AVS_WRITEDATA[i*8 +: 8];
            end
        end
        if (!s_q.waitreq)
            s_d.waitreq = 1'b1;
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            s_q         <= '0;
            s_q.pipe    <= PS_IDLE;
            s_q.waitreq <= 1'b1;
            s_q.exec.kind <= OPK_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    assign MEM_REQ        = s_q.mem;
    assign MEM_CACHE_FILL = s_q.mem.valid && !s_q.mem.is_store && CACHE_ENABLE;
    assign ADDR_ERROR     = s_q.align_fault;
    assign TLB_MISS       = s_q.tlb_fault;
    assign EXEC_REQ       = s_q.exec;
    assign FIELDS         = s_q.fields;
    assign AVS_READDATA   = s_q.rdata;
    assign AVS_WAITREQUEST = !(bus_req && !s_q.waitreq);

    a_load_stall_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
        (hazard && s_q.pipe == PS_IDLE) |=> ISSUE_STALL && s_q.pipe == PS_STALL)
        else $error("dependent read after load not stalled");

    a_word_align_chk: assert property (@(posedge MCLK) disable iff (!RESETN)
        (accept && is_ls && !ISSUE_DOUBLE && eaddr[1:0] != 2'h0) |=> ADDR_ERROR && !MEM_REQ.valid)
        else $error("misaligned word access not flagged");

    a_dbl_align_chk: assert property (@(posedge MCLK) disable iff (!RESETN)
        (accept && is_ls && ISSUE_DOUBLE && eaddr[2:0] != 3'h0) |=> ADDR_ERROR)
        else $error("misaligned doubleword access not flagged");

    a_tlb_miss_flag: assert property (@(posedge MCLK) disable iff (!RESETN)
        (accept && is_ls && !TLB_HIT) |=> TLB_MISS && !MEM_REQ.valid)
        else $error("TLB miss not raised");

    a_reserved_nowrite: assert property (@(posedge MCLK) disable iff (!RESETN)
        EXEC_REQ.valid && EXEC_REQ.unimplemented |-> !EXEC_REQ.dest_write)
        else $error("reserved code writes destination");

    a_fmt_reserved: assert property (@(posedge MCLK) disable iff (!RESETN)
        (accept && !is_ls && f.opcode == FLOAT_COPROCESSOR_OPCODE && f.fmt == 5'h12)
        |=> EXEC_REQ.unimplemented)
        else $error("reserved format accepted");

    a_compare_range: assert property (@(posedge MCLK) disable iff (!RESETN)
        (accept && !is_ls && f.opcode == FLOAT_COPROCESSOR_OPCODE && f.func[5:4] == 2'b11)
        |=> EXEC_REQ.kind == OPK_CMP)
        else $error("compare code misdecoded");

    a_even_row_32: assert property (@(posedge MCLK) disable iff (!RESETN)
        (EXEC_REQ.valid && !$past(width64))
        |-> EXEC_REQ.dest_row[0] == 1'b0)
        else $error("odd row used in 32-bit mode");

    a_root_decode: assert property (@(posedge MCLK) disable iff (!RESETN)
        (accept && !is_ls && f.opcode == FLOAT_COPROCESSOR_OPCODE && f.func == 6'h04)
        |=> EXEC_REQ.kind == OPK_ROOT)
        else $error("square root code misdecoded");

endmodule

/* common/fld_pkg.sv */
// package for the floating-point load/store and computational decoder
package fld_pkg;

    // register bus map (word byte addresses)
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_DECODE  = 4'h4;
    localparam logic [3:0] ADDR_COUNT   = 4'h8;
    localparam int         STATUS_WIDTH_BIT = 26;

    // instruction field positions
    localparam int OP_HI   = 31;
    localparam int OP_LO   = 26;
    localparam int BASE_HI = 25;
    localparam int BASE_LO = 21;
    localparam int SRCB_HI = 20;
    localparam int SRCB_LO = 16;
    localparam int SRCA_HI = 15;
    localparam int SRCA_LO = 11;
    localparam int DST_HI  = 10;
    localparam int DST_LO  = 6;
    localparam int OFS_HI  = 15;
    localparam int OFS_LO  = 0;
    localparam int FN_HI   = 5;
    localparam int FN_LO   = 0;

    localparam logic [5:0] FLOAT_COPROCESSOR_OPCODE = 6'h11;

    // operand format codes
    localparam logic [4:0] FMT_SINGLE = 5'h10;
    localparam logic [4:0] FMT_DOUBLE = 5'h11;
    localparam logic [4:0] FMT_WORD   = 5'h14;
    localparam logic [4:0] FMT_LONG   = 5'h15;

    // function code boundaries
    localparam logic [5:0] FN_NEGATE_LAST = 6'h07;
    localparam logic [5:0] FN_TOLONG_LO  = 6'h08;
    localparam logic [5:0] FN_TOWORD_LO  = 6'h0c;
    localparam logic [5:0] FN_TOWORD_HI  = 6'h0f;
    localparam logic [5:0] FN_TO_SINGLE  = 6'h20;
    localparam logic [5:0] FN_TO_DOUBLE  = 6'h21;
    localparam logic [5:0] FN_TO_WORD    = 6'h24;
    localparam logic [5:0] FN_TO_LONG    = 6'h25;
    localparam logic [5:0] FN_COMPARE_LO = 6'h30;

    // load interlock cycles
    localparam logic [1:0] LOAD_STALL_CYCLES = 2'h1;

    typedef enum logic [1:0] {
        ACC_WORD   = 2'b00,
        ACC_DOUBLE = 2'b01
    } fld_access_t;

    typedef enum logic [4:0] {
        OPK_ADD   = 5'h00, OPK_SUB  = 5'h01, OPK_MUL  = 5'h02, OPK_DIV = 5'h03,
        OPK_ROOT  = 5'h04, OPK_MAG  = 5'h05, OPK_MOV  = 5'h06, OPK_NEGATE = 5'h07,
        OPK_RNDL  = 5'h08, OPK_TRZL = 5'h09, OPK_UPL  = 5'h0a, OPK_DNL = 5'h0b,
        OPK_RNDW  = 5'h0c, OPK_TRZW = 5'h0d, OPK_UPW  = 5'h0e, OPK_DNW = 5'h0f,
        OPK_TOS   = 5'h10, OPK_TOD  = 5'h11, OPK_TOW  = 5'h12, OPK_TOL = 5'h13,
        OPK_CMP   = 5'h14, OPK_NONE = 5'h1f
    } fld_opkind_t;

    typedef enum logic [1:0] {
        PS_IDLE  = 2'b00,
        PS_STALL = 2'b01
    } fld_pipe_t;

    // one decoded instruction
    typedef struct packed {
        logic [5:0]  opcode;
        logic [4:0]  base;
        logic [4:0]  fmt;
        logic [4:0]  src_two;
        logic [4:0]  src_one;
        logic [4:0]  dest;
        logic [5:0]  func;
        logic [15:0] offset;
    } fld_fields_t;

    // memory-side request
    typedef struct packed {
        logic        valid;
        logic        is_store;
        fld_access_t acc;
        logic [31:0] vaddr;
        logic [4:0]  row;
        logic        high_half;
    } fld_mem_t;

    // compute-side dispatch
    typedef struct packed {
        logic        valid;
        fld_opkind_t kind;
        logic [4:0]  src_one_row;
        logic [4:0]  src_two_row;
        logic [4:0]  dest_row;
        logic        pair_access;
        logic        dest_write;
        logic        unimplemented;
        logic        odd_register;
    } fld_exec_t;

    typedef struct packed {
        fld_pipe_t   pipe;
        logic [1:0]  stall_cnt;
        logic [4:0]  load_dest;
        logic        load_pending;
        fld_fields_t fields;
        fld_mem_t    mem;
        fld_exec_t   exec;
        logic        align_fault;
        logic        tlb_fault;
        logic [31:0] status;
        logic [15:0] stalls;
        logic        waitreq;
        logic [31:0] rdata;
    } fld_state_t;

endpackage

/* bench/fld_far_model.sv */
// far-side model: memory port and execution unit that record what the decoder sends
`timescale 1ns/10ps
module fld_far_model
    import fld_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // requests from the decoder
    input  wire fld_mem_t  mem_req,
    input  wire logic      cache_fill,
    input  wire fld_exec_t exec_req,
    // recorded traffic
    output fld_mem_t       last_mem,
    output fld_exec_t      last_exec,
    output logic [31:0]    n_mem,
    output logic [31:0]    n_fill,
    output logic [31:0]    n_misalign
);
    always @(posedge clk) begin
        if (!rst_n) begin
            n_mem <= 32'h0;
            n_fill <= 32'h0;
            n_misalign <= 32'h0;
        end else begin
            if (exec_req.valid === 1'b1) begin
                last_exec <= exec_req;
            end
            if (mem_req.valid === 1'b1) begin
                last_mem <= mem_req;
                n_mem <= n_mem + 32'h1;
                // memory only serves naturally aligned words and doublewords
                if ((mem_req.acc == ACC_WORD && mem_req.vaddr[1:0] != 2'h0) ||
                    (mem_req.acc == ACC_DOUBLE && mem_req.vaddr[2:0] != 3'h0)) begin
                    n_misalign <= n_misalign + 32'h1;
                end
            end
            if (cache_fill === 1'b1) begin
                n_fill <= n_fill + 32'h1;
            end
        end
    end
endmodule

/* bench/fld_decoder_tb.sv */
// self-checking testbench for the floating-point instruction decoder
`timescale 1ns/10ps
module fld_decoder_tb;
    import fld_pkg::*;
    // load opcode value is arbitrary; the decoder is told by ISSUE_IS_LOAD
    localparam logic [5:0] LD_OP = 6'h31;
    logic MCLK = 1'b0, RESETN = 1'b0;
    logic ISSUE_VALID = 1'b0, ISSUE_IS_LOAD = 1'b0, ISSUE_IS_STORE = 1'b0, ISSUE_DOUBLE = 1'b0;
    logic [31:0] ISSUE_WORD = 32'h0, ISSUE_BASE_VALUE = 32'h0, AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
    logic ISSUE_STALL, TLB_HIT = 1'b1, CACHE_ENABLE = 1'b1, MEM_CACHE_FILL, ADDR_ERROR, TLB_MISS;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
    logic AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
    fld_mem_t MEM_REQ, last_mem;
    fld_exec_t EXEC_REQ, last_exec;
    fld_fields_t FIELDS;
    logic [31:0] n_mem, n_fill, n_misalign, m0;
    int n_mismatch = 0, checks = 0, stl;
    logic [4:0] k;

    always #12.5 MCLK = ~MCLK;

    fld_decoder uut (.MCLK(MCLK), .RESETN(RESETN), .ISSUE_VALID(ISSUE_VALID), .ISSUE_IS_LOAD(ISSUE_IS_LOAD),
        .ISSUE_IS_STORE(ISSUE_IS_STORE), .ISSUE_DOUBLE(ISSUE_DOUBLE), .ISSUE_WORD(ISSUE_WORD),
        .ISSUE_BASE_VALUE(ISSUE_BASE_VALUE), .ISSUE_STALL(ISSUE_STALL), .TLB_HIT(TLB_HIT),
        .CACHE_ENABLE(CACHE_ENABLE), .MEM_REQ(MEM_REQ), .MEM_CACHE_FILL(MEM_CACHE_FILL),
        .ADDR_ERROR(ADDR_ERROR), .TLB_MISS(TLB_MISS), .EXEC_REQ(EXEC_REQ), .FIELDS(FIELDS),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));

    fld_far_model far (.clk(MCLK), .rst_n(RESETN), .mem_req(MEM_REQ), .cache_fill(MEM_CACHE_FILL),
        .exec_req(EXEC_REQ), .last_mem(last_mem), .last_exec(last_exec), .n_mem(n_mem), .n_fill(n_fill),
        .n_misalign(n_misalign));

    function automatic logic [31:0] cw(input logic [4:0] fmt, sb, sa, dn, input logic [5:0] fn);
        return {FLOAT_COPROCESSOR_OPCODE, fmt, sb, sa, dn, fn};
    endfunction

    function automatic logic [31:0] lsw(input logic [4:0] base, sb, input logic [15:0] off);
        return {LD_OP, base, sb, off};
    endfunction

    function automatic logic [4:0] kind_of(input int f);
        if (f < 16) return f[4:0];
        if (f == 32) return OPK_TOS;
        if (f == 33) return OPK_TOD;
        if (f == 36) return OPK_TOW;
        if (f == 37) return OPK_TOL;
        if (f >= 48) return OPK_CMP;
        return OPK_NONE;
    endfunction

    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // register bus access: hold until waitrequest is seen low, then release
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= wd;
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        // the rising edge that sees waitrequest low completes the access
        do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
        r = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    // present one instruction from a rising edge and return at the edge that accepts it
    task automatic issue(input logic ld, st, dbl, input logic [31:0] w, base, output int s);
        ISSUE_VALID <= 1'b1;
        ISSUE_IS_LOAD <= ld;
        ISSUE_IS_STORE <= st;
        ISSUE_DOUBLE <= dbl;
        ISSUE_WORD <= w;
        ISSUE_BASE_VALUE <= base;
        s = 0;
        for (int i = 0; i < 50; i++) begin
            @(negedge MCLK);
            if (ISSUE_STALL !== 1'b1) break;
            s++;
        end
        @(posedge MCLK);
    endtask

    task automatic retire;
        ISSUE_VALID <= 1'b0;
        @(posedge MCLK);
        @(negedge MCLK);
    endtask

    task automatic op(input logic ld, st, dbl, input logic [31:0] w, base);
        @(posedge MCLK);
        m0 = n_mem;
        issue(ld, st, dbl, w, base, stl);
        retire();
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge MCLK);
        RESETN <= 1'b1;
        bus(1'b0, ADDR_STATUS, 32'h0, rd); chk(rd[STATUS_WIDTH_BIT], 1'b0);
        bus(1'b1, 4'hc, 32'hffffffff, rd);
        bus(1'b0, 4'hc, 32'h0, rd); chk(rd, 32'h0);
        // word load to odd register 3 with a negative offset, 32-bit mode
        op(1'b1, 1'b0, 1'b0, lsw(5'd1, 5'd3, 16'hfffc), 32'h1000);
        chk(last_mem.vaddr, 32'h0ffc);
        chk({30'h0, last_mem.acc}, {30'h0, ACC_WORD});
        chk({27'h0, last_mem.row}, 32'h2);
        chk({31'h0, last_mem.high_half}, 32'h1);
        chk(n_fill, 32'h1);
        chk({FIELDS.base, FIELDS.offset}, {5'd1, 16'hfffc});
        // alignment: word at +2, double at +4 refused; aligned double store and word store pass
        for (int j = 0; j < 4; j++) begin
            op(1'b0, 1'b1, j[0], lsw(5'd2, 5'd4, 16'h0), 32'h1000 + ((j < 2) ? 32'h2 << j : 32'h8));
            chk({31'h0, ADDR_ERROR}, {31'h0, j < 2});
            chk(n_mem - m0, (j < 2) ? 32'h0 : 32'h1);
        end
        chk({31'h0, last_mem.is_store}, 32'h1);
        chk(n_fill, 32'h1);
        chk(n_misalign, 32'h0);
        @(posedge MCLK);
        TLB_HIT <= 1'b0;
        op(1'b1, 1'b0, 1'b1, lsw(5'd2, 5'd6, 16'h10), 32'h2000);
        chk({31'h0, TLB_MISS}, 32'h1);
        chk(n_mem - m0, 32'h0);
        @(posedge MCLK);
        TLB_HIT <= 1'b1;
        // load followed directly by a reader of the loaded register through either source, then by an instruction that reads neither
        for (int j = 0; j < 3; j++) begin
            @(posedge MCLK);
            issue(1'b1, 1'b0, 1'b0, lsw(5'd1, 5'd4, 16'h0), 32'h3000, stl);
            issue(1'b0, 1'b0, 1'b0, cw(FMT_SINGLE, (j == 1) ? 5'd4 : 5'd8, (j == 0) ? 5'd4 : 5'd10, 5'd12, 6'h0),
                  32'h0, stl);
            retire();
            chk(stl, (j < 2) ? 32'd2 : 32'd0);
        end
        bus(1'b0, ADDR_COUNT, 32'h0, rd);
        chk(rd, 32'h2);
        for (int f = 0; f < 64; f++) begin
            op(1'b0, 1'b0, 1'b0, cw(FMT_SINGLE, 5'd2, 5'd4, 5'd6, f[5:0]), 32'h0);
            k = kind_of(f);
            chk({27'h0, last_exec.kind}, {27'h0, k});
            chk({31'h0, last_exec.unimplemented}, {31'h0, k == OPK_NONE});
            chk({31'h0, last_exec.dest_write}, {31'h0, k != OPK_NONE && k != OPK_CMP});
        end
        for (int f = 16; f < 32; f++) begin
            op(1'b0, 1'b0, 1'b0, cw(f[4:0], 5'd2, 5'd4, 5'd6, (f == 20 || f == 21) ? 6'h20 : 6'h0), 32'h0);
            k = (f == 16 || f == 17 || f == 20 || f == 21) ? 5'h0 : 5'h1;
            chk({31'h0, last_exec.unimplemented}, {27'h0, k});
            chk({31'h0, last_exec.dest_write}, {31'h0, k == 5'h0});
        end
        op(1'b0, 1'b0, 1'b0, cw(FMT_DOUBLE, 5'd4, 5'd2, 5'd6, 6'h0), 32'h0);
        chk({FIELDS.opcode, FIELDS.fmt, FIELDS.src_two, FIELDS.src_one, FIELDS.dest, FIELDS.func},
            cw(FMT_DOUBLE, 5'd4, 5'd2, 5'd6, 6'h0));
        chk({31'h0, last_exec.pair_access}, 32'h1);
        op(1'b0, 1'b0, 1'b0, cw(FMT_SINGLE, 5'd4, 5'd3, 5'd6, 6'h0), 32'h0);
        chk({31'h0, last_exec.odd_register}, 32'h1);
        chk({27'h0, last_exec.src_one_row}, 32'h2);
        chk({31'h0, last_exec.pair_access}, 32'h0);
        // switch to 64-bit registers
        bus(1'b1, ADDR_STATUS, 32'h1 << STATUS_WIDTH_BIT, rd);
        bus(1'b0, ADDR_STATUS, 32'h0, rd); chk(rd, 32'h1 << STATUS_WIDTH_BIT);
        op(1'b0, 1'b0, 1'b0, cw(FMT_DOUBLE, 5'd5, 5'd3, 5'd7, 6'h1), 32'h0);
        chk({31'h0, last_exec.odd_register}, 32'h0);
        chk({22'h0, last_exec.src_one_row, last_exec.src_two_row}, {22'h0, 5'd3, 5'd5});
        chk({27'h0, last_exec.dest_row}, 32'h7);
        chk({31'h0, last_exec.pair_access}, 32'h0);
        bus(1'b0, ADDR_DECODE, 32'h0, rd);
        chk(rd, {27'h0, OPK_SUB});
        @(posedge MCLK);
        CACHE_ENABLE <= 1'b0;
        op(1'b1, 1'b0, 1'b0, lsw(5'd1, 5'd3, 16'h8), 32'h4000);
        chk(n_fill, 32'h4);
        chk({26'h0, last_mem.row, last_mem.high_half}, {26'h0, 5'd3, 1'b0});
        tally_and_finish();
    end
endmodule
